// ### tat_pkg.sv
// Constants and types shared by the type A sixteen-bit timer.
package tat_pkg;

    // Register word offsets (byte addresses).
    localparam logic [15:0] OFF_CTRL   = 16'h0600;
    localparam logic [15:0] OFF_COUNT  = 16'h0610;
    localparam logic [15:0] OFF_PERIOD = 16'h0620;
    localparam logic [15:0] OFF_STATUS = 16'h0630;

    // Alias sub-offsets inside each register block.
    localparam logic [3:0] SUB_WRITE = 4'h0;
    localparam logic [3:0] SUB_CLR   = 4'h4;
    localparam logic [3:0] SUB_SET   = 4'h8;
    localparam logic [3:0] SUB_INV   = 4'hC;

    // Control register field positions.
    localparam int BIT_ON      = 15;
    localparam int BIT_IDLE    = 13;
    localparam int BIT_WBLOCK  = 12;
    localparam int BIT_PENDING = 11;
    localparam int BIT_ECS_HI  = 9;
    localparam int BIT_ECS_LO  = 8;
    localparam int BIT_GATE    = 7;
    localparam int BIT_PS_HI   = 5;
    localparam int BIT_PS_LO   = 4;
    localparam int BIT_SYNC    = 2;
    localparam int BIT_CS      = 1;

    // Status register field position.
    localparam int BIT_MATCH = 0;

    // Reset values.
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

    // External clock select codes.
    localparam logic [1:0] ECS_SOSC   = 2'h0;
    localparam logic [1:0] ECS_PIN    = 2'h1;
    localparam logic [1:0] ECS_RC_OSC = 2'h2;

    // Prescaler terminal counts for 1:1, 1:8, 1:64 and 1:256.
    localparam logic [7:0] PS_TERM_1   = 8'h00;
    localparam logic [7:0] PS_TERM_8   = 8'h07;
    localparam logic [7:0] PS_TERM_64  = 8'h3F;
    localparam logic [7:0] PS_TERM_256 = 8'hFF;

    typedef struct packed {
        logic       on;
        logic       idle_stop;
        logic       async_write_block;
        logic [1:0] external_clock_select;
        logic       gate_accumulate_enable;
        logic [1:0] prescale_select;
        logic       external_clock_sync;
        logic       clock_source_select;
    } tat_ctrl_t;

    localparam tat_ctrl_t CTRL_RESET = '0;

endpackage : tat_pkg

// ### tat_timer.sv
// Type A sixteen-bit timer with an APB register slave.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

// Overview of operation
// (R1) Timer counts only while enable bit set.
// (R2) Idle-stop bit halts timer in idle mode.
// (R3) Write block ignores count writes while pending.
// (R4) Pending bit shows unfinished asynchronous count write.
// (R5) Pending bit reads zero in synchronous mode.
// (R6) Select field picks oscillator, pin or RC.
// (R7) Gate bit accumulates gated time, internal only.
// (R8) Prescaler divides by 1, 8, 64, 256.
// (R9) Sync bit synchronises external input, external only.
// (R10) Source bit picks external or peripheral clock.
// (R11) Unimplemented control bits read as zero.
// (R12) Reset clears control, count; period all ones.
// (R13) Clear, set, invert aliases at plus 4, 8, C.
// (R14) Software avoids access right after disabling.
// (R15) Four counting modes, synchronous and asynchronous.
// (R16) Count wraps at period, raising match event.
// (R17) Pending clears once transferred value loads.
module tat_timer (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata_q,
    output logic             pready_q,
    output logic             pslverr_q,
    // Device state
    input  wire logic        idle_mode,
    // External clock sources, asynchronous to clock
    input  wire logic        sosc_in,
    input  wire logic        timer_clock_pin,
    input  wire logic        low_power_rc_oscillator,
    // Events and state
    output logic             period_match_q,
    output logic             timer_running_q
);

    // Register state.
    tat_pkg::tat_ctrl_t ctrl_q;
    logic [15:0]        count_q;
    logic [15:0]        period_q;
    logic               match_flag_q;

    // Asynchronous write transfer.
    logic               pending_q;
    logic [15:0]        hold_q;

    // Input synchronisers and edge detection.
    logic [2:0]         in_s1_q;
    logic [2:0]         in_s2_q;
    logic               ext_prev_q;
    logic               ext_prev2_q;

    // Prescaler.
    logic [7:0]         psc_q;

    // Combinational terms.
    logic [15:0]        base;
    logic [3:0]         sub;
    logic               sel_ctrl;
    logic               sel_count;
    logic               sel_period;
    logic               sel_status;
    logic               mapped;
    logic               setup;
    logic               wr_en;
    logic               async_mode;
    logic               pend_rd;
    logic [31:0]        ctrl_word;
    logic [31:0]        ctrl_new;
    logic [31:0]        count_new;
    logic [31:0]        period_new;
    logic [31:0]        rdata;
    logic               cnt_wr;
    logic               cnt_accept;
    logic               ext_lvl;
    logic               gate_lvl;
    logic               edge_async;
    logic               edge_sync;
    logic               ext_evt;
    logic               src_evt;
    logic               run;
    logic [7:0]         ps_term;
    logic               tick;
    logic               at_period;
    logic               async_load;

    // Alias write: plain store, clear, set or toggle of written ones.
    function automatic logic [31:0] alias_apply(
        input logic [3:0]  s,
        input logic [31:0] old,
        input logic [31:0] wd
    );
        logic [31:0] r;
        r = old;
        case (s)
            tat_pkg::SUB_WRITE: r = wd;
            tat_pkg::SUB_CLR:   r = old & ~wd;
            tat_pkg::SUB_SET:   r = old | wd;
            tat_pkg::SUB_INV:   r = old ^ wd;
            default:            r = old;
        endcase
        return r;
    endfunction : alias_apply

    // APB address decode.
    assign base       = {paddr[15:4], 4'h0};
    assign sub        = paddr[3:0];
    assign sel_ctrl   = (base == tat_pkg::OFF_CTRL);
    assign sel_count  = (base == tat_pkg::OFF_COUNT);
    assign sel_period = (base == tat_pkg::OFF_PERIOD);
    assign sel_status = (base == tat_pkg::OFF_STATUS);
    assign mapped     = (paddr[1:0] == 2'h0)
                      & (sel_ctrl | sel_count | sel_period | sel_status);
    assign setup      = psel & ~penable;
    assign wr_en      = psel & penable & pwrite & pready_q & mapped;

    // Asynchronous mode is an external source counted without synchronisation.
    assign async_mode = ctrl_q.clock_source_select & ~ctrl_q.external_clock_sync; // see (R15)
    assign pend_rd    = pending_q & async_mode; // see (R4) see (R5)

    // Control word image; unimplemented bits stay zero.
    always_comb begin
        ctrl_word                          = 32'h0000_0000; // see (R11)
        ctrl_word[tat_pkg::BIT_ON]         = ctrl_q.on;
        ctrl_word[tat_pkg::BIT_IDLE]       = ctrl_q.idle_stop;
        ctrl_word[tat_pkg::BIT_WBLOCK]     = ctrl_q.async_write_block;
        ctrl_word[tat_pkg::BIT_PENDING]    = pend_rd;
        ctrl_word[tat_pkg::BIT_ECS_HI:tat_pkg::BIT_ECS_LO] = ctrl_q.external_clock_select;
        ctrl_word[tat_pkg::BIT_GATE]       = ctrl_q.gate_accumulate_enable;
        ctrl_word[tat_pkg::BIT_PS_HI:tat_pkg::BIT_PS_LO]   = ctrl_q.prescale_select;
        ctrl_word[tat_pkg::BIT_SYNC]       = ctrl_q.external_clock_sync;
        ctrl_word[tat_pkg::BIT_CS]         = ctrl_q.clock_source_select;
    end

    assign ctrl_new   = alias_apply(sub, ctrl_word, pwdata); // see (R13)
    assign count_new  = alias_apply(sub, {16'h0000, count_q}, pwdata); // see (R13)
    assign period_new = alias_apply(sub, {16'h0000, period_q}, pwdata); // see (R13)

    // Read mux; alias addresses read back the register they belong to.
    always_comb begin
        rdata = 32'h0000_0000;
        if (sel_ctrl) begin
            rdata = ctrl_word;
        end else if (sel_count) begin
            rdata = {16'h0000, count_q};
        end else if (sel_period) begin
            rdata = {16'h0000, period_q};
        end else if (sel_status) begin
            rdata[tat_pkg::BIT_MATCH] = match_flag_q;
        end
    end

    // APB answer: one access cycle, data prepared during setup.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q  <= (setup & ~pwrite & mapped) ? rdata : 32'h0000_0000;
        end
    end

    // Control register.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_q <= tat_pkg::CTRL_RESET; // see (R12)
        end else if (wr_en & sel_ctrl) begin
            ctrl_q.on                     <= ctrl_new[tat_pkg::BIT_ON];
            ctrl_q.idle_stop              <= ctrl_new[tat_pkg::BIT_IDLE];
            ctrl_q.async_write_block      <= ctrl_new[tat_pkg::BIT_WBLOCK];
            ctrl_q.external_clock_select  <=
                ctrl_new[tat_pkg::BIT_ECS_HI:tat_pkg::BIT_ECS_LO];
            ctrl_q.gate_accumulate_enable <= ctrl_new[tat_pkg::BIT_GATE];
            ctrl_q.prescale_select        <=
                ctrl_new[tat_pkg::BIT_PS_HI:tat_pkg::BIT_PS_LO];
            ctrl_q.external_clock_sync    <= ctrl_new[tat_pkg::BIT_SYNC];
            ctrl_q.clock_source_select    <= ctrl_new[tat_pkg::BIT_CS];
        end
    end

    // Period register.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            period_q <= tat_pkg::PERIOD_RESET; // see (R12)
        end else if (wr_en & sel_period) begin
            period_q <= period_new[15:0];
        end
    end

    // External sources pass two flip-flops before any logic sees them.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            in_s1_q <= 3'h0;
            in_s2_q <= 3'h0;
        end else begin
            in_s1_q <= {low_power_rc_oscillator, timer_clock_pin, sosc_in};
            in_s2_q <= in_s1_q;
        end
    end

    // Source selection; the reserved code yields no edges.
    always_comb begin
        case (ctrl_q.external_clock_select) // see (R6)
            tat_pkg::ECS_SOSC: ext_lvl = in_s2_q[0];
            tat_pkg::ECS_PIN:  ext_lvl = in_s2_q[1];
            tat_pkg::ECS_RC_OSC: ext_lvl = in_s2_q[2];
            default:           ext_lvl = 1'b0;
        endcase
    end

    // The pin doubles as the gate input in internal mode.
    assign gate_lvl = in_s2_q[1];

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ext_prev_q  <= 1'b0;
            ext_prev2_q <= 1'b0;
        end else begin
            ext_prev_q  <= ext_lvl;
            ext_prev2_q <= ext_prev_q;
        end
    end

    // Synchronised mode resamples once more, trading a cycle of latency
    // for alignment with the register clock.
    assign edge_async = ext_lvl & ~ext_prev_q;
    assign edge_sync  = ext_prev_q & ~ext_prev2_q;
    assign ext_evt    = ctrl_q.external_clock_sync ? edge_sync : edge_async; // see (R9)

    // Gating applies only to the internal clock.
    always_comb begin
        if (ctrl_q.clock_source_select) begin // see (R10)
            src_evt = ext_evt; // see (R7)
        end else if (ctrl_q.gate_accumulate_enable) begin
            src_evt = gate_lvl; // see (R7)
        end else begin
            src_evt = 1'b1;
        end
    end

    // Enable and idle-stop together decide whether the timer runs.
    assign run = ctrl_q.on // see (R1)
               & ~(ctrl_q.idle_stop & idle_mode); // see (R2)

    always_comb begin
        case (ctrl_q.prescale_select) // see (R8)
            2'h0:    ps_term = tat_pkg::PS_TERM_1;
            2'h1:    ps_term = tat_pkg::PS_TERM_8;
            2'h2:    ps_term = tat_pkg::PS_TERM_64;
            2'h3:    ps_term = tat_pkg::PS_TERM_256;
            default: ps_term = tat_pkg::PS_TERM_1;
        endcase
    end

    // Prescaler restarts whenever the timer stops.
    always_ff @(posedge clock) begin
        if (sys_rst | ~run) begin
            psc_q <= 8'h00;
        end else if (src_evt) begin
            psc_q <= (psc_q >= ps_term) ? 8'h00 : psc_q + 8'h01; // see (R8)
        end
    end

    assign tick      = run & src_evt & (psc_q >= ps_term);
    assign at_period = (count_q == period_q);

    // Count writes and the asynchronous transfer.
    assign cnt_wr     = wr_en & sel_count;
    assign cnt_accept = cnt_wr
                      & ~(async_mode & ctrl_q.async_write_block & pending_q); // see (R3)
    // The held value lands on the next source edge, even while disabled,
    // so a write made before enabling is not left hanging.
    assign async_load = pending_q & edge_async; // see (R17)

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hold_q <= tat_pkg::COUNT_RESET;
        end else if (cnt_accept & async_mode) begin
            hold_q <= count_new[15:0];
        end
    end

    // A fresh accepted write wins over the load finishing in the same cycle.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pending_q <= 1'b0;
        end else if (~async_mode) begin
            pending_q <= 1'b0; // see (R5)
        end else if (cnt_accept) begin
            pending_q <= 1'b1; // see (R4)
        end else if (async_load) begin
            pending_q <= 1'b0; // see (R17)
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_q <= tat_pkg::COUNT_RESET; // see (R12)
        end else if (cnt_accept & ~async_mode) begin
            count_q <= count_new[15:0];
        end else if (async_load) begin
            count_q <= hold_q; // see (R17)
        end else if (tick) begin
            count_q <= at_period ? 16'h0000 : count_q + 16'h0001; // see (R16)
        end
    end

    // Match event: one-cycle pulse plus a sticky flag cleared by writing one.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            period_match_q <= 1'b0;
        end else begin
            period_match_q <= tick & at_period; // see (R16)
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            match_flag_q <= 1'b0;
        end else if (tick & at_period) begin
            match_flag_q <= 1'b1; // see (R16)
        end else if (wr_en & sel_status & pwdata[tat_pkg::BIT_MATCH]) begin
            match_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            timer_running_q <= 1'b0;
        end else begin
            timer_running_q <= run;
        end
    end

endmodule : tat_timer

// ### tat_checker.sv
// Port-level assertions for the type A timer.
`timescale 1ns/1ps
module tat_checker (
    // Clock and reset
    input wire logic        clock,
    input wire logic        sys_rst,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata_q,
    input wire logic        pready_q,
    input wire logic        pslverr_q,
    // Events and state
    input wire logic        period_match_q,
    input wire logic        timer_running_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_ready_after_setup: assert property ((psel && !penable) |=> pready_q)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready_q |=> !pready_q)
        else $error("pready held too long");
    a_err_unaligned: assert property ((psel && !penable && paddr[1:0] != 2'h0) |=> pslverr_q)
        else $error("unaligned access accepted");
    a_err_with_ready: assert property (pslverr_q |-> pready_q && prdata_q == 32'h0)
        else $error("error response malformed");
    a_upper_read_zero: assert property ((pready_q && !pwrite) |-> prdata_q[31:16] == 16'h0)
        else $error("upper read bits set");
    a_ctrl_unused_zero: assert property ((pready_q && !pwrite && paddr[15:4] == 12'h060)
        |-> !prdata_q[14] && !prdata_q[10] && !prdata_q[6] && !prdata_q[3] && !prdata_q[0])
        else $error("unimplemented control bit set");
    a_match_pulse_only: assert property (period_match_q |=> !period_match_q)
        else $error("match flag not a pulse");
    a_match_needs_run: assert property (period_match_q |-> timer_running_q || $past(timer_running_q))
        else $error("match while stopped");
    a_quiet_after_reset: assert property ($fell(sys_rst) |-> !pready_q && !period_match_q
        && !timer_running_q)
        else $error("outputs active after reset");
endmodule : tat_checker

bind tat_timer tat_checker u_chk (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .period_match_q(period_match_q),
    .timer_running_q(timer_running_q));

// ### tat_timer_tb_top.sv
// Self-checking testbench for the type A timer.
`timescale 1ns/1ps
module tat_timer_tb_top;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        idle_mode = 1'b0;
    logic [2:0]  ext = 3'h0;
    logic        period_match_q;
    logic        timer_running_q;
    int          n_errors = 0;
    int          n_compared = 0;
    logic [31:0] rd;
    logic        er;
    int          gap;
    // Prescale ratios for the four prescale codes.
    int          ps_div [4] = '{1, 8, 64, 256};

    typedef struct packed {
        logic        wr;
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] exp;
        logic        err;
    } tat_row_t;
    // Rows run in order: reset values first, then the alias writes build on each other.
    tat_row_t rows [13] = '{
        '{1'b0, 16'h0600, 32'h0, 32'h00000000, 1'b0}, '{1'b0, 16'h0610, 32'h0, 32'h0, 1'b0},
        '{1'b0, 16'h0620, 32'h0, 32'h0000FFFF, 1'b0},
        '{1'b1, 16'h0600, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 16'h0600, 32'h0, 32'h0000B3B6, 1'b0},
        '{1'b1, 16'h0604, 32'h0000B000, 32'h0, 1'b0}, '{1'b0, 16'h0600, 32'h0, 32'h000003B6, 1'b0},
        '{1'b1, 16'h0608, 32'h00008000, 32'h0, 1'b0}, '{1'b1, 16'h060C, 32'h00000086, 32'h0, 1'b0},
        '{1'b0, 16'h0600, 32'h0, 32'h00008330, 1'b0}, '{1'b1, 16'h0620, 32'h12345678, 32'h0, 1'b0},
        '{1'b0, 16'h0620, 32'h0, 32'h00005678, 1'b0}, '{1'b0, 16'h0700, 32'h0, 32'h0, 1'b1}};

    tat_timer DUT (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .idle_mode(idle_mode),
        .sosc_in(ext[0]), .timer_clock_pin(ext[1]), .low_power_rc_oscillator(ext[2]),
        .period_match_q(period_match_q), .timer_running_q(timer_running_q));

    always #2.5 clock = ~clock;

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    // The request is held until pready is sampled high; only the watchdog ends a lost wait.
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready_q !== 1'b1);
        rd = prdata_q;
        er = pslverr_q;
        check("wait_states", n, 32'h1);
        // Releasing here leaves an idle cycle before the next setup.
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask : rd_chk

    task pulse(input logic [2:0] m, input int n);
        repeat (n) begin
            ext <= m;
            repeat (4) @(posedge clock);
            ext <= 3'h0;
            repeat (4) @(posedge clock);
        end
    endtask : pulse

    task wait_match(output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (period_match_q !== 1'b1);
    endtask : wait_match

    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            check("row_err", er, rows[i].err);
            if (!rows[i].wr) check("row_data", rd, rows[i].exp);
        end
        apb(1'b0, 16'h0602, 32'h0);
        check("unaligned_err", er, 1'b1);
        apb(1'b1, 16'h0620, 32'h4);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 16'h0600, 32'h0);
            apb(1'b1, 16'h0610, 32'h0);
            apb(1'b1, 16'h0600, 32'h00008000 | (k << 4));
            wait_match(gap);
            wait_match(gap);
            check("match_gap", gap, 5 * ps_div[k]);
        end
        apb(1'b1, 16'h0600, 32'h0);
        rd_chk("match_flag", 16'h0630, 32'h1);
        apb(1'b1, 16'h0630, 32'h1);
        rd_chk("match_clear", 16'h0630, 32'h0);
        apb(1'b0, 16'h0610, 32'h0);
        gap = rd;
        repeat (10) @(posedge clock);
        rd_chk("stopped_count", 16'h0610, gap);
        apb(1'b1, 16'h0620, 32'hFFFF);
        apb(1'b1, 16'h0610, 32'h0);
        apb(1'b1, 16'h0600, 32'h00008080);
        repeat (20) @(posedge clock);
        rd_chk("gate_low", 16'h0610, 32'h0);
        ext <= 3'h2;
        repeat (20) @(posedge clock);
        ext <= 3'h0;
        apb(1'b0, 16'h0610, 32'h0);
        check("gate_high", rd != 32'h0, 1'b1);
        idle_mode <= 1'b1;
        apb(1'b1, 16'h0600, 32'h0000A000);
        repeat (3) @(posedge clock);
        check("idle_halt", timer_running_q, 1'b0);
        apb(1'b1, 16'h0600, 32'h00008000);
        repeat (3) @(posedge clock);
        check("idle_run", timer_running_q, 1'b1);
        idle_mode <= 1'b0;
        apb(1'b1, 16'h0600, 32'h00001102);
        apb(1'b1, 16'h0610, 32'h0055);
        rd_chk("pending_set", 16'h0600, 32'h00001902);
        apb(1'b1, 16'h0610, 32'h0077);
        pulse(3'h2, 1);
        rd_chk("pending_clear", 16'h0600, 32'h00001102);
        rd_chk("async_loaded", 16'h0610, 32'h0055);
        // With the block bit off a second write replaces the held value.
        apb(1'b1, 16'h0600, 32'h00000102);
        apb(1'b1, 16'h0610, 32'h0011);
        apb(1'b1, 16'h0610, 32'h0022);
        pulse(3'h2, 1);
        rd_chk("legacy_write", 16'h0610, 32'h0022);
        // Leave asynchronous mode with a write still pending.
        apb(1'b1, 16'h0610, 32'h0033);
        apb(1'b1, 16'h0600, 32'h00000106);
        rd_chk("sync_pending", 16'h0600, 32'h00000106);
        apb(1'b1, 16'h0600, 32'h00001102);
        rd_chk("pending_dropped", 16'h0600, 32'h00001102);
        apb(1'b1, 16'h0600, 32'h0);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 16'h0610, 32'h0);
            apb(1'b1, 16'h0600, 32'h00008006 | (k << 8));
            pulse((k == 3) ? 3'h7 : (3'h1 << k), 3);
            apb(1'b1, 16'h0600, 32'h0);
            rd_chk("ext_count", 16'h0610, (k == 3) ? 32'h0 : 32'h3);
        end
        // Reset in mid-run must bring control, count and period back to their reset values.
        apb(1'b1, 16'h0620, 32'h1234);
        apb(1'b1, 16'h0610, 32'h0099);
        apb(1'b1, 16'h0600, 32'h00008000);
        sys_rst <= 1'b1;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        check("reset_running", timer_running_q, 1'b0);
        rd_chk("reset_ctrl", 16'h0600, 32'h0);
        rd_chk("reset_count", 16'h0610, 32'h0);
        rd_chk("reset_period", 16'h0620, 32'h0000FFFF);
        give_verdict();
    end
endmodule : tat_timer_tb_top
